//--- sefl_pkg.sv
/*
 * Shared constants and carrier types for the serial port event flag logic.
 * Assumes an APB master with 32-bit data and an external shift engine.
 */
`default_nettype none
package sefl_pkg;
    // Bus, byte and flag widths, synchroniser depth
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned FLAG_W = 4;
    localparam int unsigned SYNC_N = 3;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_DATA = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h0c;

    // Control register bit positions
    localparam int unsigned BIT_DONE  = 7;
    localparam int unsigned BIT_WRITE_COLLISION_FLAG  = 6;
    localparam int unsigned BIT_MODE_FAULT_FLAG  = 5;
    localparam int unsigned BIT_OVR   = 4;
    localparam int unsigned BIT_MULTI = 3;
    localparam int unsigned BIT_IEN   = 2;
    localparam int unsigned BIT_MASTER_ENABLE = 1;
    localparam int unsigned BIT_PEN   = 0;

    // Index of each flag inside the flag vector
    localparam int unsigned F_DONE = 3;
    localparam int unsigned F_WRITE_COLLISION_FLAG = 2;
    localparam int unsigned F_MODE_FAULT_FLAG = 1;
    localparam int unsigned F_OVR  = 0;

    // Reset values
    localparam logic [FLAG_W-1:0] FLAG_RST = 4'h0;
    localparam logic [FLAG_W-1:0] MASK_RST = 4'hf;
    localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
    localparam logic [DATA_W-1:0] WORD_RST = 32'h0000_0000;

    // From the shift engine
    typedef struct packed {
        logic              xfer_done;
        logic              tx_taken;
        logic [BYTE_W-1:0] rx_byte;
    } sefl_eng_in_t;

    // To the shift engine
    typedef struct packed {
        logic [BYTE_W-1:0] tx_byte;
        logic              tx_full;
        logic              shift_lock;
        logic              master_enable;
        logic              port_enable;
    } sefl_eng_out_t;
endpackage
`default_nettype wire

//--- sefl_top.sv
/*
 * Event and error flags of a master/slave serial port, with APB registers,
 * transmit latch, receive buffer, mode-fault self-disable and interrupt.
 * Assumes an external shift engine on pclk, raw pins for serial clock and
 * slave select, and an APB master that holds its request until pready.
 */
// Functional notes
// - With interrupts enabled, any set flag whose mask bit is one requests an interrupt.
// - Hardware never clears a flag; only software does.
// - Byte-complete flag, control bit 7, sets after every byte transfer.
// - Write-collision flag, bit 6, sets on data write while transmit latch full.
// - A colliding data write is dropped; transmit latch keeps its contents.
// - Mode-fault flag, bit 5, sets when multimaster master sees select low.
// - A mode fault clears master enable and port enable.
// - Overrun flag, bit 4, sets when slave transfer ends with unread byte.
// - On overrun the old byte stays, the new byte is lost.
// - Slave locks shift register at first clock edge, latch holds until end.
`timescale 1ns/1ps
`default_nettype none
module sefl_top (
    // Clock and reset
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    // APB slave
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [sefl_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [sefl_pkg::DATA_W-1:0]  pwdata,
    output logic      [sefl_pkg::DATA_W-1:0]  prdata,
    output logic                              pready,
    output logic                              pslverr,
    // Serial pins, asynchronous
    input  wire logic                         sclk_in,
    input  wire logic                         slave_select_in,
    // Shift engine
    input  wire sefl_pkg::sefl_eng_in_t       eng_in,
    output var  sefl_pkg::sefl_eng_out_t      eng_out,
    // Interrupt
    output logic                              irq
);
    import sefl_pkg::*;

    // Settled value moves only once stages two and three agree
    function automatic logic f_settle(input logic s2, input logic s3, input logic old);
        f_settle = (s2 == s3) ? s2 : old;
    endfunction

    logic [FLAG_W-1:0] flag_reg;
    logic [FLAG_W-1:0] flag_next;
    logic [FLAG_W-1:0] mask_reg;
    logic              multi_reg;
    logic              ien_reg;
    logic              master_enable_reg;
    logic              master_enable_next;
    logic              pen_reg;
    logic              pen_next;
    logic [BYTE_W-1:0] tx_buf_reg;
    logic              tx_full_reg;
    logic              tx_full_next;
    logic [BYTE_W-1:0] rx_buf_reg;
    logic              rx_full_reg;
    logic              rx_full_next;
    logic              lock_reg;
    logic              lock_next;
    logic [SYNC_N-1:0] sclk_sync_reg;
    logic [SYNC_N-1:0] nss_sync_reg;
    logic              sclk_st_reg;
    logic              sclk_st_next;
    logic              nss_st_reg;
    logic              nss_st_next;
    logic [DATA_W-1:0] prdata_reg;
    logic [DATA_W-1:0] prdata_next;
    logic              pready_reg;
    logic              pslverr_reg;
    logic              irq_reg;
    logic              irq_next;

    // APB phase decode; a transfer completes when pready is seen high
    wire acc      = psel & penable;
    wire acc_new  = acc & ~pready_reg;
    wire xfer_ok  = acc & pready_reg;
    wire wr       = xfer_ok & pwrite;
    wire rd       = xfer_ok & ~pwrite;
    wire hit_ctrl = (paddr == ADDR_CTRL);
    wire hit_data = (paddr == ADDR_DATA);
    wire hit_stat = (paddr == ADDR_STAT);
    wire hit_mask = (paddr == ADDR_MASK);
    wire mapped   = hit_ctrl | hit_data | hit_stat | hit_mask;

    // Read views of the registers
    wire [BYTE_W-1:0] ctrl_view = {flag_reg, multi_reg, ien_reg, master_enable_reg, pen_reg};
    wire [DATA_W-1:0] rd_mux =
        hit_ctrl ? {{(DATA_W-BYTE_W){1'b0}}, ctrl_view} :
        hit_data ? {{(DATA_W-BYTE_W){1'b0}}, rx_buf_reg} :
        hit_stat ? {{(DATA_W-FLAG_W){1'b0}}, flag_reg} :
        hit_mask ? {{(DATA_W-FLAG_W){1'b0}}, mask_reg} : WORD_RST;

    // Pin filtering; first stage feeds only the second
    assign sclk_st_next = f_settle(sclk_sync_reg[1], sclk_sync_reg[2], sclk_st_reg);
    assign nss_st_next  = f_settle(nss_sync_reg[1], nss_sync_reg[2], nss_st_reg);
    wire   sclk_edge    = (sclk_st_next != sclk_st_reg);

    // Flag events
    // byte done event
    wire done_evt = eng_in.xfer_done;
    wire write_collision_flag_evt = wr & hit_data & tx_full_reg;
    wire mode_fault_flag_evt = pen_reg & master_enable_reg & multi_reg & ~nss_st_reg;
    wire rx_read  = rd & hit_data;
    wire ovr_evt  = eng_in.xfer_done & ~master_enable_reg & rx_full_reg & ~rx_read;

    wire [FLAG_W-1:0] set_vec = {done_evt, write_collision_flag_evt, mode_fault_flag_evt, ovr_evt};
    // zero in control or one in status clears
    wire [FLAG_W-1:0] clr_ctrl = (wr & hit_ctrl) ? ~pwdata[BIT_DONE:BIT_OVR] : FLAG_RST;
    wire [FLAG_W-1:0] clr_stat = (wr & hit_stat) ? pwdata[FLAG_W-1:0] : FLAG_RST;
    wire [FLAG_W-1:0] clr_vec  = clr_ctrl | clr_stat;
    // flags drop only on software clear
    assign flag_next = (flag_reg & ~clr_vec) | set_vec;

    // Enables; fault beats a simultaneous software write
    // self-disable on mode fault
    assign master_enable_next = mode_fault_flag_evt ? 1'b0 : ((wr & hit_ctrl) ? pwdata[BIT_MASTER_ENABLE] : master_enable_reg);
    assign pen_next   = mode_fault_flag_evt ? 1'b0 : ((wr & hit_ctrl) ? pwdata[BIT_PEN] : pen_reg);

    // Transmit latch; engine may only take it while not locked
    // colliding write leaves latch alone
    wire tx_load = wr & hit_data & ~tx_full_reg;
    wire tx_take = eng_in.tx_taken & tx_full_reg & ~lock_reg;
    assign tx_full_next = tx_load | (tx_full_reg & ~tx_take);

    // slave lock at first serial edge
    wire lock_set = pen_reg & ~master_enable_reg & sclk_edge & ~lock_reg;
    assign lock_next = lock_set | (lock_reg & ~eng_in.xfer_done);

    // Receive buffer
    // overrun keeps old byte
    wire rx_store = eng_in.xfer_done & ~ovr_evt;
    assign rx_full_next = rx_store | (rx_full_reg & ~rx_read);

    // Next enable and mask; irq must follow a register write in the same cycle
    wire              ien_next  = (wr & hit_ctrl) ? pwdata[BIT_IEN] : ien_reg;
    wire [FLAG_W-1:0] mask_next = (wr & hit_mask) ? pwdata[FLAG_W-1:0] : mask_reg;

    // Registered from next values so irq tracks the registers exactly
    // interrupt on set flags
    assign irq_next = ien_next & (|(flag_next & mask_next));

    // Read data captured as pready rises; bus sees it with pready
    assign prdata_next = (acc_new & ~pwrite) ? rd_mux : WORD_RST;

    // Pin synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_sync_reg <= '0;
            nss_sync_reg  <= '1;
            sclk_st_reg   <= 1'b0;
            nss_st_reg    <= 1'b1;
        end else begin
            sclk_sync_reg <= {sclk_sync_reg[SYNC_N-2:0], sclk_in};
            nss_sync_reg  <= {nss_sync_reg[SYNC_N-2:0], slave_select_in};
            sclk_st_reg   <= sclk_st_next;
            nss_st_reg    <= nss_st_next;
        end
    end

    // Flags, control and interrupt
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_reg  <= FLAG_RST;
            mask_reg  <= MASK_RST;
            multi_reg <= 1'b0;
            ien_reg   <= 1'b0;
            master_enable_reg <= 1'b0;
            pen_reg   <= 1'b0;
            irq_reg   <= 1'b0;
        end else begin
            flag_reg  <= flag_next;
            master_enable_reg <= master_enable_next;
            pen_reg   <= pen_next;
            irq_reg   <= irq_next;
            ien_reg   <= ien_next;
            mask_reg  <= mask_next;
            if (wr && hit_ctrl) begin
                multi_reg <= pwdata[BIT_MULTI];
            end
        end
    end

    // Data path
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_buf_reg  <= BYTE_RST;
            tx_full_reg <= 1'b0;
            rx_buf_reg  <= BYTE_RST;
            rx_full_reg <= 1'b0;
            lock_reg    <= 1'b0;
        end else begin
            tx_full_reg <= tx_full_next;
            rx_full_reg <= rx_full_next;
            lock_reg    <= lock_next;
            if (tx_load) begin
                tx_buf_reg <= pwdata[BYTE_W-1:0];
            end
            if (rx_store) begin
                rx_buf_reg <= eng_in.rx_byte;
            end
        end
    end

    // APB answer, one wait state per transfer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= WORD_RST;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            prdata_reg  <= prdata_next;
            pready_reg  <= acc_new;
            pslverr_reg <= acc_new & ~mapped;
        end
    end

    // Outputs
    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq     = irq_reg;
    assign eng_out = '{tx_byte: tx_buf_reg, tx_full: tx_full_reg, shift_lock: lock_reg,
                       master_enable: master_enable_reg, port_enable: pen_reg};

    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_irq_level: assert property (irq_reg == (ien_reg && |(flag_reg & mask_reg)))
        else $error("irq does not match enabled masked flags");
    a_irq_held: assert property (irq_reg ##1 ($stable(flag_reg) && $stable(mask_reg) && $stable(ien_reg)) |-> irq_reg)
        else $error("irq dropped while flags held");
    a_flags_sticky: assert property (($past(flag_reg) & ~$past(clr_vec) & ~flag_reg) == FLAG_RST)
        else $error("flag cleared without software");
    a_done_set: assert property (eng_in.xfer_done |=> flag_reg[F_DONE] && ctrl_view[BIT_DONE])
        else $error("byte done flag not set");
    a_write_collision_flag_set: assert property (wr && hit_data && tx_full_reg |=> flag_reg[F_WRITE_COLLISION_FLAG])
        else $error("collision flag not set");
    a_write_collision_flag_drop: assert property (write_collision_flag_evt |=> $stable(tx_buf_reg) && tx_full_reg)
        else $error("colliding write changed latch");
    a_mode_fault_flag_set: assert property (mode_fault_flag_evt |=> flag_reg[F_MODE_FAULT_FLAG])
        else $error("mode fault flag not set");
    a_mode_fault_flag_off: assert property (mode_fault_flag_evt |=> !master_enable_reg && !pen_reg ##1 !eng_out.master_enable)
        else $error("mode fault left port enabled");
    a_ovr_set: assert property (ovr_evt |=> flag_reg[F_OVR] && ctrl_view[BIT_OVR])
        else $error("overrun flag not set");
    a_ovr_keep: assert property (ovr_evt |=> $stable(rx_buf_reg) && rx_full_reg)
        else $error("overrun byte overwrote buffer");
    a_lock_hold: assert property (lock_reg && tx_full_reg && !eng_in.xfer_done |=> tx_full_reg)
        else $error("latch drained while locked");
    a_set_wins: assert property (set_vec[F_DONE] && clr_vec[F_DONE] |=> flag_reg[F_DONE])
        else $error("clear beat a same-cycle set");
    a_apb_answer: assert property (acc_new |=> pready_reg ##1 !pready_reg)
        else $error("apb answer not one cycle");

    c_mode_fault: cover property (pen_reg && master_enable_reg ##1 mode_fault_flag_evt);
    c_overrun: cover property (rx_store ##[1:40] ovr_evt);
    c_collision: cover property (tx_load ##[1:20] write_collision_flag_evt);
    c_lock_cycle: cover property (lock_set ##[1:400] eng_in.xfer_done);
endmodule
`default_nettype wire

//--- sefl_far_master.sv
/*
 * Far-side serial master model: per frame it pulls select low and gives
 * eight link clock pulses at a 200 ns period.
 * Assumes the bench raises start once for each frame it wants.
 */
`timescale 1ns/1ps
`default_nettype none
module sefl_far_master (
    // Frame request from the bench
    input  wire logic start,
    // Serial pins
    output logic      sclk,
    output logic      select_n
);
    // Clock stands still low between frames; select idles high
    initial begin
        sclk     = 1'b0;
        select_n = 1'b1;
    end

    // Odd start offset keeps link edges unrelated to pclk
    always @(posedge start) begin
        #57 select_n = 1'b0;
        #100;
        repeat (8) begin
            #100 sclk = 1'b1;
            #100 sclk = 1'b0;
        end
        #100 select_n = 1'b1;
    end
endmodule
`default_nettype wire

//--- testbench.sv
/*
 * Self-checking bench for the serial port event flags: APB tasks, shift
 * engine pulses from the bench, a far-side master model on the pins.
 * Assumes the design answers each APB access within a few cycles.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fails++; $display("ERROR %0t: got %h expected %h", $time, a, e); end end
module testbench;
    import sefl_pkg::*;
    logic              pclk, presetn, psel, penable, pwrite, start;
    logic              pready, pslverr, irq, sclk, select_n, last_err;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    sefl_eng_in_t      eng;
    sefl_eng_out_t     eo;
    int                fails = 0;
    int                n_compared = 0;

    // Design and far-side model
    sefl_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sclk_in(sclk), .slave_select_in(select_n), .eng_in(eng), .eng_out(eo), .irq(irq));
    sefl_far_master far_u (.start(start), .sclk(sclk), .select_n(select_n));

    // System clock, 25 ns period
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // One APB transfer; idle edge after it so psel is never set twice per step
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fails++;
            $display("ERROR %0t: no pready on apb access", $time);
        end
        rd       = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        apb(1'b0, a, '0);
        `CHK(rd, e)
    endtask

    // Shift engine pulses, one cycle wide
    task automatic pulse_done(input logic [BYTE_W-1:0] b);
        eng.rx_byte   <= b;
        eng.xfer_done <= 1'b1;
        @(posedge pclk);
        eng.xfer_done <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic pulse_taken;
        eng.tx_taken <= 1'b1;
        @(posedge pclk);
        eng.tx_taken <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic tally_and_finish;
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        fails++;
        $display("ERROR %0t: watchdog expired", $time);
        tally_and_finish();
    end

    initial begin
        {psel, penable, pwrite, start} = '0;
        paddr   = '0;
        pwdata  = '0;
        eng     = '0;
        presetn = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk(ADDR_CTRL, 32'h0000_0000);
        `CHK(last_err, 1'b0)
        rd_chk(ADDR_MASK, 32'h0000_000f);
        // Byte done in master mode, held until software clears it
        apb(1'b1, ADDR_CTRL, 32'h0000_0007);
        pulse_done(8'h5a);
        `CHK(irq, 1'b1)
        repeat (40) @(posedge pclk);
        rd_chk(ADDR_CTRL, 32'h0000_0087);
        rd_chk(ADDR_DATA, 32'h0000_005a);
        apb(1'b1, ADDR_CTRL, 32'h0000_0007);
        `CHK(irq, 1'b0)
        // Back-to-back data writes collide
        apb(1'b1, ADDR_DATA, 32'h0000_0011);
        apb(1'b1, ADDR_DATA, 32'h0000_0022);
        `CHK(eo.tx_byte, 8'h11)
        rd_chk(ADDR_CTRL, 32'h0000_0047);
        pulse_taken();
        `CHK(eo.tx_full, 1'b0)
        // Slave overrun keeps the unread byte
        apb(1'b1, ADDR_CTRL, 32'h0000_0005);
        pulse_done(8'h33);
        pulse_done(8'h44);
        rd_chk(ADDR_CTRL, 32'h0000_0095);
        rd_chk(ADDR_DATA, 32'h0000_0033);
        pulse_done(8'h55);
        rd_chk(ADDR_DATA, 32'h0000_0055);
        apb(1'b1, ADDR_CTRL, 32'h0000_0005);
        // Slave lock from first link edge to end of byte
        apb(1'b1, ADDR_DATA, 32'h0000_0066);
        start <= 1'b1;
        for (int i = 0; i < 200 && eo.shift_lock !== 1'b1; i++) begin
            @(posedge pclk);
        end
        `CHK(eo.shift_lock, 1'b1)
        pulse_taken();
        `CHK(eo.tx_full, 1'b1)
        start <= 1'b0;
        for (int i = 0; i < 200 && select_n !== 1'b1; i++) begin
            @(posedge pclk);
        end
        repeat (4) @(posedge pclk);
        pulse_done(8'h77);
        `CHK(eo.shift_lock, 1'b0)
        pulse_taken();
        `CHK(eo.tx_full, 1'b0)
        // Multimaster master sees select low
        apb(1'b1, ADDR_CTRL, 32'h0000_000b);
        start <= 1'b1;
        for (int i = 0; i < 200 && eo.port_enable !== 1'b0; i++) begin
            @(posedge pclk);
        end
        `CHK(eo.master_enable, 1'b0)
        `CHK(eo.port_enable, 1'b0)
        rd_chk(ADDR_CTRL, 32'h0000_0028);
        rd_chk(ADDR_STAT, 32'h0000_0002);
        `CHK(irq, 1'b0)
        // Enable, then mask, then clear through status
        apb(1'b1, ADDR_CTRL, 32'h0000_0024);
        `CHK(irq, 1'b1)
        apb(1'b1, ADDR_MASK, 32'h0000_000d);
        `CHK(irq, 1'b0)
        apb(1'b1, ADDR_STAT, 32'h0000_0002);
        rd_chk(ADDR_CTRL, 32'h0000_0004);
        // Unmapped address is refused
        rd_chk(8'h10, 32'h0000_0000);
        `CHK(last_err, 1'b1)
        // Clear write and byte done at the same edge: the set must win
        rd_chk(ADDR_DATA, 32'h0000_0077);
        fork
            apb(1'b1, ADDR_CTRL, 32'h0000_0004);
            begin
                repeat (2) @(posedge pclk);
                eng.rx_byte   <= 8'h88;
                eng.xfer_done <= 1'b1;
                @(posedge pclk);
                eng.xfer_done <= 1'b0;
            end
        join
        rd_chk(ADDR_CTRL, 32'h0000_0084);
        `CHK(irq, 1'b1)
        tally_and_finish();
    end
endmodule
`default_nettype wire
